/* verif/fpe_sequencer_assertions.sv */
`timescale 1ns/1ps
module fpe_sequencer_assertions (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // inputs watched
   input wire logic launch,
   input wire logic cmd_allowed,
   input wire logic [17:0] protect_lo,
   input wire logic [17:0] protect_hi,
   input wire logic dflash_protected,
   // outputs watched
   input fpe_pkg::fpe_array_req_t array_req,
   input wire logic array_req_valid,
   input wire logic cmd_complete_flag,
   input fpe_pkg::fpe_status_t flash_status_reg,
   input wire logic pflash_read_invalid,
   input wire logic security_released
);
   // ****************
   // sequencer checks
   // ****************
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_launch; launch && cmd_complete_flag; endsequence
   sequence s_refused; launch && cmd_complete_flag && !cmd_allowed; endsequence
   chk_launch_busy: assert property (s_launch |-> ##[1:2] !cmd_complete_flag)
      else $error("complete flag did not fall after launch");
   chk_refuse_time: assert property (s_refused |-> ##[3:4] cmd_complete_flag
      && flash_status_reg.access_error_flag) else $error("refused launch not quick");
   chk_refuse_quiet: assert property (s_refused |=> !array_req_valid [*4])
      else $error("refused launch touched the array");
   chk_busy_array: assert property (array_req_valid |-> !cmd_complete_flag)
      else $error("array busy with complete flag set");
   chk_once_blind: assert property (array_req_valid && array_req.once |-> pflash_read_invalid)
      else $error("reads not marked invalid in one-time program");
   // one-time requests carry a phrase index, not a flash address
   chk_prog_target: assert property (array_req_valid && array_req.prog && !array_req.once |->
      array_req.addr[2:0] == 3'h0 && array_req.addr >= fpe_pkg::PFLASH_BASE)
      else $error("program target misaligned or outside flash");
   chk_prog_unprot: assert property (array_req_valid && array_req.prog && !array_req.once |->
      protect_hi < protect_lo || array_req.addr < protect_lo || array_req.addr > protect_hi)
      else $error("protected phrase programmed");
   chk_erase_unprot: assert property (array_req_valid && array_req.erase_all |->
      protect_hi < protect_lo && !dflash_protected) else $error("erase all under protection");
   chk_dblk_unprot: assert property (array_req_valid && array_req.erase_blk
      && array_req.addr[17:16] == fpe_pkg::BLK_DFLASH |-> !dflash_protected)
      else $error("protected data block erased");
   chk_secure_clean: assert property ($rose(security_released)
      |-> !flash_status_reg.verify_error_flag) else $error("security released after bad verify");
endmodule : fpe_sequencer_assertions

bind fpe_sequencer fpe_sequencer_assertions u_chk (.clock(clock), .rst_n(rst_n),
   .launch(launch), .cmd_allowed(cmd_allowed), .protect_lo(protect_lo),
   .protect_hi(protect_hi), .dflash_protected(dflash_protected), .array_req(array_req),
   .array_req_valid(array_req_valid), .cmd_complete_flag(cmd_complete_flag),
   .flash_status_reg(flash_status_reg), .pflash_read_invalid(pflash_read_invalid),
   .security_released(security_released));

/* verif/test_flash_program_erase_commands.sv */
`timescale 1ns/1ps
module test_flash_program_erase_commands;
   // ****************
   // bench state
   // ****************
   localparam logic [17:0] PB = fpe_pkg::PFLASH_BASE;
   localparam logic [63:0] DW = 64'h0123_4567_89ab_cdee;
   localparam logic [63:0] ONES = 64'hffff_ffff_ffff_ffff;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic param_wr = 1'b0;
   logic [2:0] param_slot_index = 3'h0;
   logic [15:0] cmd_param_reg = 16'h0;
   logic launch = 1'b0;
   logic clear_errors = 1'b0;
   logic cmd_allowed = 1'b1;
   logic [17:0] protect_lo = 18'h3ffff;
   logic [17:0] protect_hi = 18'h0;
   logic dflash_protected = 1'b0;
   logic array_done = 1'b0;
   logic [63:0] array_rdata = 64'h0;
   logic array_rd_uncorrectable = 1'b0;
   logic [63:0] rd_val = 64'h0;
   logic rd_unc = 1'b0;
   logic saw_valid = 1'b0;
   logic saw_inv = 1'b0;
   logic array_req_valid, cmd_complete_flag, pflash_read_invalid, security_released;
   fpe_pkg::fpe_array_req_t array_req, req_seen;
   fpe_pkg::fpe_status_t flash_status_reg;
   int miscompares = 0;
   int num_checks = 0;
   int n_edges = 0;
   always #50 clock = ~clock;
   fpe_sequencer #(.PROG_WAIT(2), .ERASE_WAIT(2)) dut (.clock(clock), .rst_n(rst_n),
      .param_wr(param_wr), .param_slot_index(param_slot_index), .cmd_param_reg(cmd_param_reg),
      .launch(launch), .clear_errors(clear_errors), .cmd_allowed(cmd_allowed),
      .protect_lo(protect_lo), .protect_hi(protect_hi), .dflash_protected(dflash_protected),
      .array_req(array_req), .array_req_valid(array_req_valid), .array_done(array_done),
      .array_rdata(array_rdata), .array_rd_uncorrectable(array_rd_uncorrectable),
      .cmd_complete_flag(cmd_complete_flag), .flash_status_reg(flash_status_reg),
      .pflash_read_invalid(pflash_read_invalid), .security_released(security_released));
   // array stand-in: done pulses, read data scrambled between them
   always @(posedge clock) begin
      array_done <= array_req_valid && !array_done;
      array_rdata <= (array_req_valid && !array_done) ? rd_val : ~rd_val;
      array_rd_uncorrectable <= rd_unc && array_req_valid && !array_done;
      if (array_req_valid && !saw_valid) req_seen <= array_req;
      if (array_req_valid) saw_valid <= 1'b1;
      if (pflash_read_invalid) saw_inv <= 1'b1;
   end
   task automatic chk_stat(input string what, input logic [3:0] exp, input logic [3:0] got);
      num_checks++;
      if (got !== exp) begin miscompares++; $display("[ERR] %s expected %h seen %h", what, exp, got); end
   endtask : chk_stat
   task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin miscompares++; $display("[ERR] %s expected %h seen %h", what, exp, got); end
   endtask : chk_val
   // slots 0..l, launch, then wait idle without touching anything
   task automatic run_cmd(input logic [7:0] c, input logic [17:0] a, input logic [63:0] d,
      input logic [2:0] l, input logic [63:0] rd, input logic unc);
      @(posedge clock);
      rd_val <= rd; rd_unc <= unc; saw_valid <= 1'b0; saw_inv <= 1'b0; clear_errors <= 1'b1;
      for (int i = 0; i <= l; i++) begin
         @(posedge clock);
         clear_errors <= 1'b0; param_wr <= 1'b1; param_slot_index <= 3'(i);
         cmd_param_reg <= (i == 0) ? {c, 6'h0, a[17:16]} : (i == 1) ? a[15:0] : d[16*(i-2) +: 16];
      end
      @(posedge clock); param_wr <= 1'b0; launch <= 1'b1;
      @(posedge clock); launch <= 1'b0;
      n_edges = 0;
      do begin @(posedge clock); #1; n_edges++; end
      while ((n_edges < 2 || cmd_complete_flag !== 1'b1) && n_edges < 300);
      chk_val("complete flag", 64'h1, 64'(cmd_complete_flag));
   endtask : run_cmd
   task automatic abort_case(input logic [7:0] c, input logic [17:0] a, input logic [2:0] l,
      input logic [3:0] e);
      run_cmd(c, a, DW, l, DW, 1'b0);
      chk_stat("abort status", e, flash_status_reg);
      chk_val("abort time", 64'h1, 64'(n_edges <= 4));
      chk_val("array untouched", 64'h0, 64'(saw_valid));
   endtask : abort_case
   task automatic t_program();
      run_cmd(fpe_pkg::CMD_PROG_PHRASE, PB + 18'h8, DW, 3'h5, DW, 1'b0);
      chk_stat("program status", 4'h0, flash_status_reg);
      chk_val("program request", {1'b1, PB + 18'h8, DW}, {req_seen.prog, req_seen.addr, req_seen.data});
      run_cmd(fpe_pkg::CMD_PROG_PHRASE, PB, DW, 3'h5, ~DW, 1'b0);
      chk_stat("verify error", 4'h2, flash_status_reg);
      run_cmd(fpe_pkg::CMD_PROG_PHRASE, PB, DW, 3'h5, ~DW, 1'b1);
      chk_stat("uncorrectable", 4'h3, flash_status_reg);
      $display("t_program done");
   endtask : t_program
   task automatic t_once();
      for (int k = 0; k < 2; k++) begin
         run_cmd(fpe_pkg::CMD_PROG_ONCE, 18'h7, ONES, 3'h5, ONES, 1'b0);
         chk_stat("one-time status", 4'h0, flash_status_reg);
         chk_val("one-time seen", 64'h3, {req_seen.once, saw_inv});
      end
      run_cmd(fpe_pkg::CMD_PROG_ONCE, 18'h2, DW, 3'h5, DW, 1'b0);
      chk_stat("one-time refused", 4'h8, flash_status_reg);
      $display("t_once done");
   endtask : t_once
   task automatic t_erase();
      run_cmd(fpe_pkg::CMD_ERASE_ALL, 18'h0, DW, 3'h0, ~ONES, 1'b0);
      chk_val("kept secure", 64'h2, {flash_status_reg.verify_error_flag, security_released});
      run_cmd(fpe_pkg::CMD_ERASE_ALL, 18'h0, DW, 3'h0, ONES, 1'b0);
      chk_val("released", 64'h3, {req_seen.erase_all, security_released});
      run_cmd(fpe_pkg::CMD_ERASE_BLOCK, PB, DW, 3'h1, ONES, 1'b0);
      chk_val("block erase", {4'h0, 1'b1, PB}, {flash_status_reg, req_seen.erase_blk, req_seen.addr});
      $display("t_erase done");
   endtask : t_erase
   task automatic t_refusals();
      abort_case(fpe_pkg::CMD_PROG_PHRASE, PB, 3'h4, 4'h8);
      abort_case(fpe_pkg::CMD_ERASE_ALL, PB, 3'h1, 4'h8);
      abort_case(fpe_pkg::CMD_ERASE_BLOCK, PB, 3'h0, 4'h8);
      abort_case(fpe_pkg::CMD_PROG_PHRASE, PB + 18'h4, 3'h5, 4'h8);
      abort_case(fpe_pkg::CMD_PROG_PHRASE, 18'h10000, 3'h5, 4'h8);
      abort_case(fpe_pkg::CMD_PROG_ONCE, 18'h8, 3'h5, 4'h8);
      abort_case(fpe_pkg::CMD_ERASE_BLOCK, 18'h10000, 3'h1, 4'h8);
      abort_case(fpe_pkg::CMD_ERASE_BLOCK, PB + 18'h4, 3'h1, 4'h8);
      abort_case(fpe_pkg::CMD_ERASE_BLOCK, 18'h1, 3'h1, 4'h8);
      cmd_allowed <= 1'b0;
      for (int k = 6; k < 10; k++) abort_case(8'(k), PB, (k < 8) ? 3'h5 : 3'(k - 8), 4'h8);
      cmd_allowed <= 1'b1; protect_lo <= PB; protect_hi <= PB + 18'h7ff;
      abort_case(fpe_pkg::CMD_PROG_PHRASE, PB, 3'h5, 4'h4);
      abort_case(fpe_pkg::CMD_ERASE_BLOCK, PB, 3'h1, 4'h4);
      abort_case(fpe_pkg::CMD_ERASE_ALL, PB, 3'h0, 4'h4);
      protect_lo <= 18'h3ffff; protect_hi <= 18'h0; dflash_protected <= 1'b1;
      abort_case(fpe_pkg::CMD_ERASE_BLOCK, 18'h0, 3'h1, 4'h4);
      abort_case(fpe_pkg::CMD_ERASE_ALL, 18'h0, 3'h0, 4'h4);
      dflash_protected <= 1'b0;
      $display("t_refusals done");
   endtask : t_refusals
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // watchdog well beyond the expected run
   initial begin #(100 * 20000); miscompares++; wrap_up(); end
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      t_program(); t_once(); t_erase(); t_refusals();
      wrap_up();
   end
endmodule : test_flash_program_erase_commands

/* verilog/fpe_pkg.sv */
package fpe_pkg;

   // ****************************************************
   // command codes and parameter slots
   // ****************************************************
   localparam logic [7:0] CMD_PROG_PHRASE = 8'h06;
   localparam logic [7:0] CMD_PROG_ONCE = 8'h07;
   localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
   localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
   localparam logic [2:0] SLOT_CMD = 3'h0;
   localparam logic [2:0] SLOT_ADDR = 3'h1;
   localparam logic [2:0] SLOT_LAST_PROG = 3'h5;
   localparam logic [2:0] SLOT_LAST_ERASE_ALL = 3'h0;
   localparam logic [2:0] SLOT_LAST_ERASE_BLK = 3'h1;
   localparam int CMD_FIELD_LSB = 8;
   localparam logic [2:0] ONCE_LAST_INDEX = 3'h7;
   localparam logic [15:0] ERASED_WORD = 16'hffff;

   // ****************************************************
   // flash map and timing
   // ****************************************************
   localparam logic [1:0] BLK_DFLASH = 2'h0;
   localparam logic [1:0] BLK_PFLASH = 2'h3;
   localparam logic [17:0] PFLASH_BASE = 18'h38000;
   localparam int PROG_TIME_NS = 20000;
   localparam int ERASE_TIME_NS = 100000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // status flags carried together
   typedef struct packed {
      logic access_error_flag;
      logic protect_violation_flag;
      logic verify_error_flag;
      logic verify_uncorrectable_flag;
   } fpe_status_t;

   // request to the flash array
   typedef struct packed {
      logic prog;
      logic erase_blk;
      logic erase_all;
      logic once;
      logic [17:0] addr;
      logic [63:0] data;
   } fpe_array_req_t;

endpackage : fpe_pkg

/* verilog/fpe_sequencer.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: program slots: code+addr high, addr low, four words
// RQ2: program, read back verify, then complete
// RQ3: final slot index checked at launch
// RQ4: program address must be phrase aligned
// RQ5: program address must be valid flash
// RQ6: protected program target flags violation
// RQ7: verify errors set the margin flags
// RQ8: unavailable mode raises access error
// RQ9: one-time slots: code, index, four words
// RQ10: one-time: blank check, program, verify
// RQ11: programmed one-time phrase refused
// RQ12: one-time index beyond seven refused
// RQ13: all-ones one-time phrase counts as blank
// RQ14: flash reads invalid during one-time program
// RQ15: host avoids running from one-time block
// RQ16: erase all, verify, then release security
// RQ17: host writes nothing during erase all
// RQ18: any protection blocks erase all
// RQ19: block erase slots, erase then verify
// RQ20: block erase alignment per flash kind
// RQ21: block erase needs valid block select
// RQ22: protected block flags violation
// RQ23: host programs only erased phrases
// RQ24: launch errors abort quickly, array untouched
module fpe_sequencer #(
   parameter int PROG_WAIT = fpe_pkg::PROG_CYCLES,
   parameter int ERASE_WAIT = fpe_pkg::ERASE_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // parameter register writes
   input wire logic param_wr,
   input wire logic [2:0] param_slot_index,
   input wire logic [15:0] cmd_param_reg,
   // launch strobe: software clears the complete flag
   input wire logic launch,
   input wire logic clear_errors,
   // chip state
   input wire logic cmd_allowed,
   input wire logic [17:0] protect_lo,
   input wire logic [17:0] protect_hi,
   input wire logic dflash_protected,
   // flash array port
   output fpe_pkg::fpe_array_req_t array_req,
   output logic array_req_valid,
   input wire logic array_done,
   input wire logic [63:0] array_rdata,
   input wire logic array_rd_uncorrectable,
   // status
   output logic cmd_complete_flag,
   output fpe_pkg::fpe_status_t flash_status_reg,
   output logic pflash_read_invalid,
   output logic security_released
);

   initial begin
      if (PROG_WAIT < 1 || ERASE_WAIT < 1) $error("wait counts must be positive");
   end

   typedef enum logic [2:0] {
      FPE_IDLE, FPE_CHECK, FPE_BLANK, FPE_WORK, FPE_WAIT, FPE_VERIFY, FPE_DONE
   } fpe_state_t;

   // ****************************************************
   // parameter slots
   // ****************************************************
   logic [15:0] slot_reg [0:5];
   logic [2:0] index_reg;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         index_reg <= 3'h0;
         for (int i = 0; i < 6; i++) slot_reg[i] <= 16'h0000;
      end else if (param_wr && cmd_complete_flag) begin
         index_reg <= param_slot_index;
         if (param_slot_index <= 3'h5) slot_reg[param_slot_index] <= cmd_param_reg;
      end
   end

   // decoded fields
   logic [7:0] code;
   logic [17:0] addr;
   logic [1:0] blk;
   logic [63:0] wdata;
   logic is_prog, is_once, is_eall, is_eblk;
   assign code = slot_reg[fpe_pkg::SLOT_CMD][15:fpe_pkg::CMD_FIELD_LSB];
   assign addr = {slot_reg[0][1:0], slot_reg[fpe_pkg::SLOT_ADDR]}; // [RQ1] [RQ19]
   assign blk = addr[17:16];
   assign wdata = {slot_reg[5], slot_reg[4], slot_reg[3], slot_reg[2]}; // [RQ1] [RQ9]
   assign is_prog = code == fpe_pkg::CMD_PROG_PHRASE;
   assign is_once = code == fpe_pkg::CMD_PROG_ONCE;
   assign is_eall = code == fpe_pkg::CMD_ERASE_ALL;
   assign is_eblk = code == fpe_pkg::CMD_ERASE_BLOCK;

   // ****************************************************
   // launch checks
   // ****************************************************
   logic acc_err, prot_err, in_prot;
   assign in_prot = addr >= protect_lo && addr <= protect_hi;
   always_comb begin
      acc_err = 1'b0;
      prot_err = 1'b0;
      if (!cmd_allowed) acc_err = 1'b1; // [RQ8]
      if (is_prog) begin
         if (index_reg != fpe_pkg::SLOT_LAST_PROG) acc_err = 1'b1; // [RQ3]
         if (addr[2:0] != 3'h0) acc_err = 1'b1; // [RQ4]
         if (addr < fpe_pkg::PFLASH_BASE) acc_err = 1'b1; // [RQ5]
         prot_err = in_prot; // [RQ6]
      end else if (is_once) begin
         if (index_reg != fpe_pkg::SLOT_LAST_PROG) acc_err = 1'b1; // [RQ3]
         if (slot_reg[1] > {13'h0000, fpe_pkg::ONCE_LAST_INDEX}) acc_err = 1'b1; // [RQ12]
      end else if (is_eall) begin
         if (index_reg != fpe_pkg::SLOT_LAST_ERASE_ALL) acc_err = 1'b1; // [RQ3]
         prot_err = dflash_protected || (protect_hi >= protect_lo); // [RQ18]
      end else if (is_eblk) begin
         if (index_reg != fpe_pkg::SLOT_LAST_ERASE_BLK) acc_err = 1'b1; // [RQ3]
         if (blk != fpe_pkg::BLK_DFLASH && blk != fpe_pkg::BLK_PFLASH) acc_err = 1'b1; // [RQ21]
         if (blk == fpe_pkg::BLK_PFLASH && addr[2:0] != 3'h0) acc_err = 1'b1; // [RQ20]
         if (blk == fpe_pkg::BLK_DFLASH && addr[0]) acc_err = 1'b1; // [RQ20]
         prot_err = (blk == fpe_pkg::BLK_PFLASH) ? (protect_hi >= protect_lo)
                                                 : dflash_protected; // [RQ22]
      end else begin
         acc_err = 1'b1;
      end
   end

   // ****************************************************
   // sequencer
   // ****************************************************
   fpe_state_t state_reg;
   logic [31:0] wait_reg;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= FPE_IDLE;
         wait_reg <= 32'h0;
      end else begin
         unique case (state_reg)
            FPE_IDLE: if (launch && cmd_complete_flag) state_reg <= FPE_CHECK;
            FPE_CHECK: begin
               if (acc_err || prot_err) state_reg <= FPE_DONE; // [RQ24]
               else if (is_once) state_reg <= FPE_BLANK; // [RQ10]
               else state_reg <= FPE_WORK;
            end
            FPE_BLANK: if (array_done) begin
               // all ones reads as blank, so it may be programmed again
               if (array_rdata == {4{fpe_pkg::ERASED_WORD}}) state_reg <= FPE_WORK; // [RQ13]
               else state_reg <= FPE_DONE; // [RQ11]
            end
            FPE_WORK: begin
               wait_reg <= (is_prog || is_once) ? PROG_WAIT : ERASE_WAIT;
               state_reg <= FPE_WAIT;
            end
            FPE_WAIT: begin
               wait_reg <= wait_reg - 32'h1;
               if (wait_reg <= 32'h1 && array_done) state_reg <= FPE_VERIFY;
            end
            FPE_VERIFY: if (array_done) state_reg <= FPE_DONE; // [RQ2] [RQ19]
            FPE_DONE: state_reg <= FPE_IDLE;
            default: state_reg <= FPE_IDLE;
         endcase
      end
   end

   // array request: blank read, operate, verify read
   always_comb begin
      array_req = '0;
      array_req.addr = is_once ? {15'h0000, slot_reg[1][2:0]} : addr;
      array_req.data = wdata;
      array_req.once = is_once;
      array_req_valid = state_reg == FPE_BLANK || state_reg == FPE_WAIT
                        || state_reg == FPE_VERIFY;
      if (state_reg == FPE_WAIT) begin
         array_req.prog = is_prog || is_once;
         array_req.erase_blk = is_eblk;
         array_req.erase_all = is_eall; // [RQ16]
      end
   end

   // verify outcome
   logic verify_bad;
   assign verify_bad = (is_prog || is_once) ? (array_rdata != wdata)
                                            : (array_rdata != {4{fpe_pkg::ERASED_WORD}});

   // ****************************************************
   // complete flag and status
   // ****************************************************
   always_ff @(posedge clock) begin
      if (!rst_n) cmd_complete_flag <= 1'b1;
      else if (state_reg == FPE_DONE) cmd_complete_flag <= 1'b1; // [RQ2] [RQ10]
      else if (state_reg == FPE_IDLE && launch) cmd_complete_flag <= 1'b0;
   end

   // flags: hardware set wins over software clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         flash_status_reg <= '0;
      end else begin
         if (state_reg == FPE_IDLE && launch && cmd_complete_flag) flash_status_reg <= '0;
         else if (clear_errors) flash_status_reg <= '0;
         if (state_reg == FPE_CHECK) begin
            if (acc_err) flash_status_reg.access_error_flag <= 1'b1;
            else if (prot_err) flash_status_reg.protect_violation_flag <= 1'b1;
         end
         if (state_reg == FPE_BLANK && array_done && array_rdata != {4{fpe_pkg::ERASED_WORD}})
            flash_status_reg.access_error_flag <= 1'b1; // [RQ11]
         if (state_reg == FPE_VERIFY && array_done) begin
            if (verify_bad) flash_status_reg.verify_error_flag <= 1'b1; // [RQ7]
            if (array_rd_uncorrectable)
               flash_status_reg.verify_uncorrectable_flag <= 1'b1; // [RQ7]
         end
      end
   end

   // invalid reads while one-time program runs
   always_ff @(posedge clock) begin
      if (!rst_n) pflash_read_invalid <= 1'b0;
      else pflash_read_invalid <= is_once && state_reg != FPE_IDLE
                                 && state_reg != FPE_DONE; // [RQ14]
   end

   // security released after a clean erase all
   always_ff @(posedge clock) begin
      if (!rst_n) security_released <= 1'b0;
      else if (state_reg == FPE_VERIFY && array_done && is_eall && !verify_bad
               && !array_rd_uncorrectable)
         security_released <= 1'b1; // [RQ16]
   end

endmodule : fpe_sequencer
